// ---- dv/pspd_partner.sv ----
`timescale 1ns/10ps
module pspd_partner (
   input  wire logic        core_clk_in, cmd_ready_out, slow,
   output logic             cmd_valid_in, fwd_ready_in,
   output logic [31:0]      cmd_data_in
);
   logic [2:0] tick = 3'h0;
   initial begin
      cmd_valid_in = 1'b0;
      cmd_data_in = 32'h0;
   end
   // slow consumer stalls two cycles of every eight
   always @(posedge core_clk_in) begin
      tick <= tick + 3'h1;
      fwd_ready_in <= !slow || tick[2:1] != 2'h3;
   end
   // whole command back to back; idle data shows the inverse
   task automatic send(input logic [31:0] d[$]);
      @(posedge core_clk_in);
      foreach (d[i]) begin
         cmd_valid_in <= 1'b1;
         cmd_data_in <= d[i];
         do @(posedge core_clk_in); while (!cmd_ready_out);
      end
      cmd_valid_in <= 1'b0;
      cmd_data_in <= ~d[d.size()-1];
   endtask
endmodule // pspd_partner

// ---- dv/pspd_props.sv ----
`timescale 1ns/10ps
module pspd_props (
   input wire logic        core_clk_in, rst_b_in, cmd_valid_in,
   input wire logic        cmd_ready_out, fwd_valid_out, fwd_ready_in,
   input wire logic        vf_setup_valid_out, ptrs_update_out,
   input wire logic        gs_enable_out, primitive_trimming_stage_enable_out,
   input wire logic [31:0] gen_state_base_in, fwd_data_out,
   input wire logic [31:0] vertex_shader_state_block_addr_out, geometry_shader_state_block_addr_out,
   input wire logic [31:0] primitive_trimming_stage_state_addr_out, sf_state_addr_out,
   input wire logic [31:0] wm_state_addr_out, cc_state_addr_out
);
   logic [31:0] base_q;
   // base as seen at the edge that took the last dword
   always_ff @(posedge core_clk_in or negedge rst_b_in)
      if (!rst_b_in) base_q <= 32'h0;
      else base_q <= gen_state_base_in;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);
   ready_rule_a: assert property (cmd_ready_out ==
      !(fwd_valid_out && !fwd_ready_in)) else $error("ready wrong");
   fwd_hold_a: assert property (fwd_valid_out && !fwd_ready_in |=>
      fwd_valid_out && $stable(fwd_data_out)) else $error("fwd dropped");
   upd_pulse_a: assert property (ptrs_update_out |=>
      !ptrs_update_out) else $error("update not a pulse");
   upd_cause_a: assert property (ptrs_update_out |->
      $past(cmd_valid_in && cmd_ready_out)) else $error("update uncaused");
   ptr_hold_a: assert property (!ptrs_update_out |-> $stable({
      vertex_shader_state_block_addr_out, geometry_shader_state_block_addr_out, primitive_trimming_stage_state_addr_out,
      sf_state_addr_out, wm_state_addr_out, cc_state_addr_out,
      gs_enable_out, primitive_trimming_stage_enable_out})) else $error("pointer moved");
   vs_align_a: assert property (ptrs_update_out |->
      vertex_shader_state_block_addr_out[4:0] == base_q[4:0]) else $error("vs misaligned");
   cc_align_a: assert property (ptrs_update_out |->
      cc_state_addr_out[5:0] == base_q[5:0]) else $error("cc misaligned");
   gs_keep_a: assert property (ptrs_update_out && !gs_enable_out |->
      $stable(geometry_shader_state_block_addr_out)) else $error("gs pointer used");
   vf_stop_a: assert property (vf_setup_valid_out |->
      !fwd_valid_out) else $error("setup dword forwarded");
   cover property (ptrs_update_out && !gs_enable_out);
   cover property (vf_setup_valid_out);
   cover property (fwd_valid_out && !fwd_ready_in);
endmodule // pspd_props
bind pspd_top pspd_props pspd_props_i (.*);

// ---- dv/tb_pspd_top.sv ----
`timescale 1ns/10ps
module tb_pspd_top import pspd_pkg::*;;
   logic        core_clk_in = 1'b0, rst_b_in = 1'b0, slow = 1'b0;
   logic        cmd_valid_in, cmd_ready_out, fwd_valid_out, fwd_ready_in;
   logic        vf_setup_valid_out, gs_enable_out, primitive_trimming_stage_enable_out;
   logic        ptrs_update_out, hdr_mbz_err_out;
   logic [31:0] cmd_data_in, gen_state_base_in = 32'h0, fwd_data_out;
   logic [31:0] vf_setup_data_out, vertex_shader_state_block_addr_out, geometry_shader_state_block_addr_out;
   logic [31:0] primitive_trimming_stage_state_addr_out, sf_state_addr_out, wm_state_addr_out;
   logic [31:0] cc_state_addr_out, lfsr = 32'h55, gs_last = PSPD_ADDR_RST;
   logic [31:0] got [7];
   logic [32:0] exp_q[$];
   int          mismatches = 0, checked = 0;
   always #4 core_clk_in = ~core_clk_in;
   pspd_top pspd_top_i (.*);
   pspd_partner pspd_partner_i (.*);
   assign got = '{vertex_shader_state_block_addr_out, geometry_shader_state_block_addr_out, primitive_trimming_stage_state_addr_out,
                  sf_state_addr_out, wm_state_addr_out, cc_state_addr_out,
                  {30'h0, gs_enable_out, primitive_trimming_stage_enable_out}};
   task automatic chk(input logic [32:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic ptr_cmd(input logic [31:0] base, input logic gs, cl,
                          input logic [7:0] rsv);
      logic [31:0] d[$];
      // base plus offset never wraps, so every block stays below 4GB
      base = base & 32'h7fff_ffff;
      d = {32'h7800_0005};
      d[0][15:8] = rsv;
      for (int i = 0; i < 6; i++)
         d.push_back(rnd() & (i == 5 ? 32'h3fff_ffc0 : 32'h3fff_ffe1));
      d[2][0] = gs;
      d[3][0] = cl;
      gen_state_base_in <= base;
      if (gs) gs_last = base + {d[2][31:5], 5'h0};
      exp_q.push_back({1'b0, base + {d[1][31:5], 5'h0}});
      exp_q.push_back({1'b0, gs_last});
      for (int i = 3; i < 6; i++)
         exp_q.push_back({1'b0, base + {d[i][31:5], 5'h0}});
      exp_q.push_back({1'b0, base + {d[6][31:6], 6'h0}});
      exp_q.push_back({31'h0, gs, cl});
      pspd_partner_i.send(d);
   endtask
   always @(posedge core_clk_in) begin
      if (fwd_valid_out && fwd_ready_in)
         chk({1'b1, fwd_data_out}, exp_q.pop_front());
      if (vf_setup_valid_out)
         chk({1'b0, vf_setup_data_out}, exp_q.pop_front());
      if (ptrs_update_out) foreach (got[i])
         chk({1'b0, got[i]}, exp_q.pop_front());
   end
   task automatic end_sim();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // bit 32 set: dwords expected on the forward stream
   logic [32:0] tbl [6] = '{33'h0_7808_0002, 33'h0_7809_0002, 33'h0_780a_0002,
                            33'h1_7801_0002, 33'h1_7900_0002, 33'h1_7000_0002};
   initial begin
      logic [31:0] d[$];
      repeat (12) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      for (int i = 0; i < 5; i++)
         ptr_cmd(rnd(), i[1], i[0], 8'h00);
      chk({32'h0, hdr_mbz_err_out}, 33'h0);
      $display("pointer test done");
      slow <= 1'b1;
      foreach (tbl[i]) begin
         d = {tbl[i][31:0], rnd(), rnd(), rnd()};
         foreach (d[j]) exp_q.push_back({tbl[i][32], d[j]});
         pspd_partner_i.send(d);
      end
      $display("setup and forward test done");
      // reserved header bits set on purpose to raise the error flag
      ptr_cmd(rnd(), 1'b0, 1'b1, 8'h5a);
      repeat (20) @(posedge core_clk_in);
      chk({1'b0, 32'(exp_q.size())}, 33'h0);
      chk({32'h0, hdr_mbz_err_out}, 33'h1);
      $display("order test done");
      end_sim();
   end
   initial begin
      #20000;
      mismatches++;
      end_sim();
   end
endmodule // tb_pspd_top

// ---- rtl/pspd_hdr_decode.sv ----
`timescale 1ns/10ps
module pspd_hdr_decode
   import pspd_pkg::*;
(
   // header
   input  wire logic [31:0] hdr_in,
   // decode
   output logic             is_ptrs_out,
   output logic             is_vf_only_out,
   output logic [7:0]       len_out
);
   logic is_3d;

   always_comb begin
      is_3d = hdr_in[31:29] == PSPD_TYPE_GFX &&
              hdr_in[28:27] == PSPD_SUBTYPE_3D;
      is_ptrs_out = is_3d && hdr_in[26:24] == PSPD_OPC_PIPED &&
                    hdr_in[23:16] == PSPD_SUB_PTRS;
      // setup commands that stop at vertex fetch
      is_vf_only_out = is_3d && hdr_in[26:24] == PSPD_OPC_PIPED &&
                       (hdr_in[23:16] == PSPD_SUB_IDXBUF ||
                        hdr_in[23:16] == PSPD_SUB_VTXBUF ||
                        hdr_in[23:16] == PSPD_SUB_VTXELEM);
      len_out = hdr_in[7:0];
   end
endmodule // pspd_hdr_decode

// ---- rtl/pspd_pkg.sv ----
// Function
// - accept the pointer command only for type 3h, subtype 3h, opcode 0h, sub-opcode 00h.
// - header bits 7:0 hold length minus two; 5h means seven dwords.
// - vertex shader pointer in dword 1 bits 31:5, added to general state base.
// - executing the command latches a new state pointer for every stage except geometry shading when dword 2 bit 0 is clear.
// - geometry shading and primitive trimming may be disabled into pass-through.
// - all other stages always enabled and fetch their pointed-to state block.
// - index, vertex buffer and vertex element setup stop at vertex fetch.
// - dword 2 bit 0 enables geometry shading; when clear its pointer is ignored.
// - dword 6 bits 31:6 give 64-byte aligned colour calculation offset.
package pspd_pkg;
   localparam logic [2:0] PSPD_TYPE_GFX     = 3'h3;
   localparam logic [1:0] PSPD_SUBTYPE_3D   = 2'h3;
   localparam logic [2:0] PSPD_OPC_PIPED    = 3'h0;
   localparam logic [2:0] PSPD_OPC_NONPIPED = 3'h1;
   localparam logic [7:0] PSPD_SUB_PTRS     = 8'h00;
   localparam logic [7:0] PSPD_SUB_IDXBUF   = 8'h0a;
   localparam logic [7:0] PSPD_SUB_VTXBUF   = 8'h08;
   localparam logic [7:0] PSPD_SUB_VTXELEM  = 8'h09;
   localparam logic [7:0] PSPD_LEN_PTRS     = 8'h05;
   localparam int         PSPD_LEN_BIAS     = 2;
   localparam int         PSPD_ALIGN32_LSB  = 5;
   localparam int         PSPD_ALIGN64_LSB  = 6;
   localparam int         PSPD_EN_BIT       = 0;
   localparam int         PSPD_NSTAGE       = 6;
   localparam int         PSPD_DW_VS        = 1;
   localparam int         PSPD_DW_GS        = 2;
   localparam int         PSPD_DW_PRIMITIVE_TRIMMING_STAGE      = 3;
   localparam int         PSPD_DW_CC        = 6;
   localparam logic [31:0] PSPD_ADDR_RST    = 32'h0000_0000;

   typedef enum logic [1:0] {
      PSPD_IDLE = 2'b00,
      PSPD_PTRS = 2'b01,
      PSPD_SKIP = 2'b10,
      PSPD_PASS = 2'b11
   } pspd_state_e;
endpackage

// ---- rtl/pspd_top.sv ----
`timescale 1ns/10ps
module pspd_top
   import pspd_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   // command stream in
   input  wire logic        cmd_valid_in,
   input  wire logic [31:0] cmd_data_in,
   output logic             cmd_ready_out,
   // general state base
   input  wire logic [31:0] gen_state_base_in,
   // stream to later stages
   output logic             fwd_valid_out,
   output logic [31:0]      fwd_data_out,
   input  wire logic        fwd_ready_in,
   // setup dwords kept at vertex fetch
   output logic             vf_setup_valid_out,
   output logic [31:0]      vf_setup_data_out,
   // stage state addresses
   output logic [31:0]      vertex_shader_state_block_addr_out,
   output logic [31:0]      geometry_shader_state_block_addr_out,
   output logic [31:0]      primitive_trimming_stage_state_addr_out,
   output logic [31:0]      sf_state_addr_out,
   output logic [31:0]      wm_state_addr_out,
   output logic [31:0]      cc_state_addr_out,
   output logic             gs_enable_out,
   output logic             primitive_trimming_stage_enable_out,
   output logic             ptrs_update_out,
   output logic             hdr_mbz_err_out
);
   pspd_state_e state;
   logic [7:0]  remain;
   logic [2:0]  dw_idx;
   logic        is_ptrs;
   logic        is_vf_only;
   logic [7:0]  hdr_len;
   logic [31:0] ptr_dw [PSPD_NSTAGE];
   logic        hdr_take;
   logic        dw_take;
   logic        cmd_ready_out_c;

   function automatic logic [31:0] pspd_add(input logic [31:0] off);
      return gen_state_base_in + off;
   endfunction

   pspd_hdr_decode u_dec (
      .hdr_in         (cmd_data_in),
      .is_ptrs_out    (is_ptrs),
      .is_vf_only_out (is_vf_only),
      .len_out        (hdr_len)
   );

   // stall input while a forward is pending so order holds
   always_comb begin
      cmd_ready_out_c = !(fwd_valid_out && !fwd_ready_in);
   end
   assign cmd_ready_out = cmd_ready_out_c;

   always_comb begin
      hdr_take = cmd_valid_in && cmd_ready_out_c && state == PSPD_IDLE;
      dw_take  = cmd_valid_in && cmd_ready_out_c && state != PSPD_IDLE;
   end

   // command walker
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state  <= PSPD_IDLE;
         remain <= 8'h00;
         dw_idx <= 3'h0;
      end else if (hdr_take) begin
         remain <= hdr_len + 8'(PSPD_LEN_BIAS - 1);
         dw_idx <= 3'h1;
         if (is_ptrs)
            state <= PSPD_PTRS;
         else if (is_vf_only)
            state <= PSPD_SKIP;
         else
            state <= PSPD_PASS;
      end else if (dw_take) begin
         remain <= remain - 8'h01;
         dw_idx <= dw_idx + 3'h1;
         if (remain == 8'h01)
            state <= PSPD_IDLE;
      end
   end

   // pointer capture, applied only once the whole command is in
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < PSPD_NSTAGE; i++)
            ptr_dw[i] <= PSPD_ADDR_RST;
      end else if (dw_take && state == PSPD_PTRS &&
                   dw_idx != 3'h0 && dw_idx <= 3'(PSPD_NSTAGE)) begin
         ptr_dw[dw_idx - 3'h1] <= cmd_data_in;
      end
   end

   // latched stage addresses; draws after the command see new values
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         vertex_shader_state_block_addr_out   <= PSPD_ADDR_RST;
         geometry_shader_state_block_addr_out   <= PSPD_ADDR_RST;
         primitive_trimming_stage_state_addr_out <= PSPD_ADDR_RST;
         sf_state_addr_out   <= PSPD_ADDR_RST;
         wm_state_addr_out   <= PSPD_ADDR_RST;
         cc_state_addr_out   <= PSPD_ADDR_RST;
         gs_enable_out       <= 1'b0;
         primitive_trimming_stage_enable_out     <= 1'b0;
         ptrs_update_out     <= 1'b0;
      end else begin
         ptrs_update_out <= 1'b0;
         if (dw_take && state == PSPD_PTRS && remain == 8'h01) begin
            // last dword arrives now: colour calc dword is cmd_data_in
            vertex_shader_state_block_addr_out <= pspd_add({ptr_dw[0][31:PSPD_ALIGN32_LSB],
                                 5'h00});
            if (ptr_dw[1][PSPD_EN_BIT])
               geometry_shader_state_block_addr_out <= pspd_add({ptr_dw[1][31:PSPD_ALIGN32_LSB],
                                    5'h00});
            primitive_trimming_stage_state_addr_out <= pspd_add({ptr_dw[2][31:PSPD_ALIGN32_LSB],
                                   5'h00});
            sf_state_addr_out <= pspd_add({ptr_dw[3][31:PSPD_ALIGN32_LSB],
                                 5'h00});
            wm_state_addr_out <= pspd_add({ptr_dw[4][31:PSPD_ALIGN32_LSB],
                                 5'h00});
            cc_state_addr_out <= pspd_add({cmd_data_in[31:PSPD_ALIGN64_LSB],
                                 6'h00});
            gs_enable_out   <= ptr_dw[1][PSPD_EN_BIT];
            primitive_trimming_stage_enable_out <= ptr_dw[2][PSPD_EN_BIT];
            ptrs_update_out <= 1'b1;
         end
      end
   end

   // header reserved field check on the pointer command
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         hdr_mbz_err_out <= 1'b0;
      else if (hdr_take && is_ptrs)
         hdr_mbz_err_out <= cmd_data_in[15:8] != 8'h00;
   end

   // forward path: everything except pointer and vertex fetch setup
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fwd_valid_out <= 1'b0;
         fwd_data_out  <= 32'h0000_0000;
      end else begin
         if (fwd_ready_in)
            fwd_valid_out <= 1'b0;
         if ((hdr_take && !is_ptrs && !is_vf_only) ||
             (dw_take && state == PSPD_PASS)) begin
            fwd_valid_out <= 1'b1;
            fwd_data_out  <= cmd_data_in;
         end
      end
   end

   // setup dwords consumed by vertex fetch, never forwarded
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         vf_setup_valid_out <= 1'b0;
         vf_setup_data_out  <= 32'h0000_0000;
      end else begin
         vf_setup_valid_out <= (hdr_take && is_vf_only) ||
                               (dw_take && state == PSPD_SKIP);
         vf_setup_data_out  <= cmd_data_in;
      end
   end
endmodule // pspd_top
